/* hw/sec_eeprom.sv */
// Serial EEPROM command logic behind the serial target port
`timescale 1ns/10ps
module sec_eeprom #(
	parameter int unsigned ProgCycles = `SEC_PROG_NS / `SEC_CLK_NS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic serialClk,
	input wire logic chipSelectN,
	input wire logic serialIn,
	input wire logic writeProtectN,
	output logic serialOut,
	output logic serialOutEn
);
	import sec_pkg::*;

	localparam int AW = `SEC_ADDR_W;
	localparam int PW = `SEC_PAGE_W;
	localparam int PB = `SEC_PAGE_BYTES;
	localparam logic [22:0] ProgLast = 23'(ProgCycles - 1);

	// Array storage, written only in the reference domain
	sec_byte_t memArray [2**AW];

	// Serial domain session registers
	sec_state_e state_reg;
	logic [2:0] bitCnt_reg;
	logic [6:0] shift_reg;
	logic hiAddr_reg;
	logic readMode_reg;
	sec_addr_t readAddr_reg;
	sec_byte_t txByte_reg;
	logic [2:0] txIdx_reg;
	// Serial domain capture registers, kept across deselect
	sec_cmd_e cmd_reg;
	sec_addr_t wrAddr_reg;
	logic [PB-1:0] pageMask_reg;
	sec_byte_t pageBuf [PB];
	sec_status_s statMeta_reg;
	sec_status_s statSync_reg;
	sec_status_s statLast_reg;
	sec_status_s statStable_reg;

	// Reference domain registers
	logic [1:0] csSync_reg;
	logic csPrev_reg;
	logic [1:0] wpSync_reg;
	logic wpLowSeen_reg;
	logic wel_reg;
	logic [1:0] protect_reg;
	logic busy_reg;
	logic [22:0] progCnt_reg;

	logic sessRst;
	sec_byte_t inByte;
	logic byteDone;
	sec_byte_t statusByte;
	sec_state_e opState;
	sec_cmd_e opCmd;
	logic csRise;
	logic csFall;
	logic commit;
	logic writeOk;
	logic guarded;
	logic startWrite;
	logic startStat;
	logic progDone;

	// Deselect ends the session at once; serial clock may be stopped then
	assign sessRst = reset | chipSelectN;
	assign inByte = {shift_reg, serialIn};
	assign byteDone = (bitCnt_reg == 3'h7);
	assign statusByte = {`SEC_ST_ONES, statStable_reg};

	// Opcode decode on the eighth bit
	always_comb begin
		opState = SEC_ST_DROP;
		opCmd = SEC_CMD_NONE;
		if (inByte == `SEC_OP_RD_STAT) begin
			opState = SEC_ST_RD_STAT;
		end else if (statStable_reg.busy) begin
			opState = SEC_ST_DROP;
		end else if ((inByte & `SEC_OP_HIADDR_MASK) == `SEC_OP_READ) begin
			opState = SEC_ST_ADDR;
		end else if ((inByte & `SEC_OP_HIADDR_MASK) == `SEC_OP_WRITE) begin
			opState = SEC_ST_ADDR;
			opCmd = SEC_CMD_WRITE;
		end else if (inByte == `SEC_OP_WR_STAT) begin
			opState = SEC_ST_DATA;
			opCmd = SEC_CMD_WR_STAT;
		end else if (inByte == `SEC_OP_SET_WEL) begin
			opState = SEC_ST_HOLD;
			opCmd = SEC_CMD_SET_WEL;
		end else if (inByte == `SEC_OP_CLR_WEL) begin
			opState = SEC_ST_HOLD;
			opCmd = SEC_CMD_CLR_WEL;
		end
	end

	// Bit counter and input shifter, sampled on rising clock
	always_ff @(posedge serialClk or posedge sessRst) begin
		if (sessRst) begin
			bitCnt_reg <= 3'h0;
			shift_reg <= 7'h00;
		end else begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
			shift_reg <= inByte[6:0]; // MSB first
		end
	end

	// Session state machine
	always_ff @(posedge serialClk or posedge sessRst) begin
		if (sessRst) begin
			state_reg <= SEC_ST_OPCODE;
			hiAddr_reg <= 1'b0;
			readMode_reg <= 1'b0;
		end else begin
			case (state_reg)
				SEC_ST_OPCODE: begin
					if (byteDone) begin
						state_reg <= opState;
						hiAddr_reg <= inByte[`SEC_OP_HIADDR_POS];
						readMode_reg <= (opState == SEC_ST_ADDR) && (opCmd == SEC_CMD_NONE);
					end
				end
				SEC_ST_ADDR: begin
					if (byteDone) begin
						state_reg <= readMode_reg ? SEC_ST_RD_ARR : SEC_ST_DATA;
					end
				end
				SEC_ST_DATA, SEC_ST_RD_ARR, SEC_ST_RD_STAT, SEC_ST_HOLD, SEC_ST_DROP: begin
					state_reg <= state_reg;
				end
				default: begin
					state_reg <= SEC_ST_DROP;
				end
			endcase
		end
	end

	// Transmit byte and read pointer; next byte loads as the last bit goes out
	always_ff @(posedge serialClk or posedge sessRst) begin
		if (sessRst) begin
			txByte_reg <= 8'h00;
			txIdx_reg <= 3'h7;
			readAddr_reg <= '0;
		end else if (state_reg == SEC_ST_OPCODE && byteDone && opState == SEC_ST_RD_STAT) begin
			txByte_reg <= statusByte;
			txIdx_reg <= 3'h7;
		end else if (state_reg == SEC_ST_ADDR && byteDone && readMode_reg) begin
			txByte_reg <= memArray[{hiAddr_reg, inByte}];
			txIdx_reg <= 3'h7;
			readAddr_reg <= AW'({hiAddr_reg, inByte} + 1'b1);
		end else if (state_reg == SEC_ST_RD_ARR || state_reg == SEC_ST_RD_STAT) begin
			if (txIdx_reg == 3'h0) begin
				txIdx_reg <= 3'h7;
				if (state_reg == SEC_ST_RD_ARR) begin
					txByte_reg <= memArray[readAddr_reg]; // wraps to zero
					readAddr_reg <= readAddr_reg + 1'b1;
				end else begin
					txByte_reg <= statusByte;
				end
			end else begin
				txIdx_reg <= txIdx_reg - 3'h1;
			end
		end
	end

	// Output driven on falling clock, released while deselected
	always_ff @(negedge serialClk or posedge sessRst) begin
		if (sessRst) begin
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
		end else begin
			serialOut <= txByte_reg[txIdx_reg];
			serialOutEn <= (state_reg == SEC_ST_RD_ARR) || (state_reg == SEC_ST_RD_STAT);
		end
	end

	// Command capture; survives deselect so the commit step can read it
	always_ff @(posedge serialClk or posedge reset) begin
		if (reset) begin
			cmd_reg <= SEC_CMD_NONE;
			wrAddr_reg <= '0;
			pageMask_reg <= '0;
		end else if (state_reg == SEC_ST_OPCODE) begin
			if (bitCnt_reg == 3'h0) begin
				cmd_reg <= SEC_CMD_NONE;
				pageMask_reg <= '0;
			end
			if (byteDone) begin
				cmd_reg <= opCmd;
				wrAddr_reg <= '0;
			end
		end else if (state_reg == SEC_ST_HOLD) begin
			// Any bit after the set opcode spoils it
			if (cmd_reg == SEC_CMD_SET_WEL) begin
				cmd_reg <= SEC_CMD_NONE;
			end
		end else if (state_reg == SEC_ST_ADDR && byteDone) begin
			wrAddr_reg <= {hiAddr_reg, inByte};
		end else if (state_reg == SEC_ST_DATA && byteDone) begin
			pageMask_reg[wrAddr_reg[PW-1:0]] <= 1'b1;
			wrAddr_reg[PW-1:0] <= wrAddr_reg[PW-1:0] + 1'b1; // page bits held
		end
	end

	// Page buffer; later bytes overwrite wrapped slots
	always_ff @(posedge serialClk) begin
		if (state_reg == SEC_ST_DATA && byteDone) begin
			pageBuf[wrAddr_reg[PW-1:0]] <= inByte;
		end
	end

	// Status into the serial domain; moves only on serial clock edges
	// Busy and latch fall together, so a word is taken only once two samples agree
	always_ff @(posedge serialClk or posedge reset) begin
		if (reset) begin
			statMeta_reg <= '0;
			statSync_reg <= '0;
			statLast_reg <= '0;
			statStable_reg <= '0;
		end else begin
			statMeta_reg <= {protect_reg, wel_reg, busy_reg};
			statSync_reg <= statMeta_reg;
			statLast_reg <= statSync_reg;
			if (statSync_reg == statLast_reg) begin
				statStable_reg <= statSync_reg; // No torn mix of old and new bits
			end
		end
	end

	// Pin synchronisers in the reference domain
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			csSync_reg <= 2'b11;
			csPrev_reg <= 1'b1;
			wpSync_reg <= 2'b11; // Idle level of the pin, no false low after reset
		end else begin
			csSync_reg <= {csSync_reg[0], chipSelectN};
			csPrev_reg <= csSync_reg[1];
			wpSync_reg <= {wpSync_reg[0], writeProtectN};
		end
	end

	assign csRise = csSync_reg[1] & ~csPrev_reg;
	assign csFall = ~csSync_reg[1] & csPrev_reg;
	assign commit = csRise & ~busy_reg;
	assign writeOk = wel_reg & wpSync_reg[1] & ~wpLowSeen_reg;
	// Guarded ranges sit on the top address bits, so any size works
	assign guarded = (protect_reg == 2'b11) || (protect_reg == 2'b10 && wrAddr_reg[AW-1])
		|| (protect_reg == 2'b01 && wrAddr_reg[AW-1] && wrAddr_reg[AW-2]);
	assign startWrite = commit && cmd_reg == SEC_CMD_WRITE && writeOk && !guarded
		&& pageMask_reg != '0;
	assign startStat = commit && cmd_reg == SEC_CMD_WR_STAT && writeOk && pageMask_reg[0];
	assign progDone = busy_reg && progCnt_reg == 23'h0;

	// Write-protect seen low in a session; a low level wins over the clear
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wpLowSeen_reg <= 1'b0;
		end else if (!csSync_reg[1] && !wpSync_reg[1]) begin
			wpLowSeen_reg <= 1'b1;
		end else if (csFall) begin
			wpLowSeen_reg <= 1'b0;
		end
	end

	// Programming timer; protect pin no longer looked at once running
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_reg <= 1'b0;
			progCnt_reg <= 23'h0;
		end else if (startWrite || startStat) begin
			busy_reg <= 1'b1;
			progCnt_reg <= ProgLast;
		end else if (progDone) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			progCnt_reg <= progCnt_reg - 23'h1;
		end
	end

	// Write-enable latch
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wel_reg <= 1'b0;
		end else if (progDone) begin
			wel_reg <= 1'b0;
		end else if (commit && cmd_reg == SEC_CMD_SET_WEL) begin
			wel_reg <= 1'b1;
		end else if (commit && cmd_reg == SEC_CMD_CLR_WEL) begin
			wel_reg <= 1'b0;
		end
	end

	// Protect bits; reset stands for a blank part, not a power cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			protect_reg <= `SEC_BP_RST;
		end else if (startStat) begin
			protect_reg <= {pageBuf[0][`SEC_ST_BP_HI_POS], pageBuf[0][`SEC_ST_BP_LO_POS]};
		end
	end

	// Array update of every loaded byte of the page
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < PB; i++) begin
			if (startWrite && pageMask_reg[i]) begin
				memArray[{wrAddr_reg[AW-1:PW], PW'(i)}] <= pageBuf[i];
			end
		end
	end
endmodule

/* pkg/sec_cfg.svh */
// Constants of the serial EEPROM command block
`ifndef SEC_CFG_SVH
`define SEC_CFG_SVH
`define SEC_ADDR_W 9
`define SEC_PAGE_W 5
`define SEC_PAGE_BYTES 32
`define SEC_OP_SET_WEL 8'h06
`define SEC_OP_CLR_WEL 8'h04
`define SEC_OP_RD_STAT 8'h05
`define SEC_OP_WR_STAT 8'h01
`define SEC_OP_READ 8'h03
`define SEC_OP_WRITE 8'h02
`define SEC_OP_HIADDR_MASK 8'hf7
`define SEC_OP_HIADDR_POS 3
`define SEC_ST_ONES 4'hf
`define SEC_ST_BP_LO_POS 2
`define SEC_ST_BP_HI_POS 3
`define SEC_BP_RST 2'b00
`define SEC_CLK_NS 8
`define SEC_PROG_NS 5000000
`endif

/* pkg/sec_pkg.sv */
// Types shared by the serial EEPROM command block
`include "sec_cfg.svh"
package sec_pkg;
	typedef logic [7:0] sec_byte_t;
	typedef logic [`SEC_ADDR_W-1:0] sec_addr_t;
	// Serial session state, one-hot
	typedef enum logic [6:0] {
		SEC_ST_OPCODE = 7'b0000001,
		SEC_ST_ADDR = 7'b0000010,
		SEC_ST_DATA = 7'b0000100,
		SEC_ST_RD_ARR = 7'b0001000,
		SEC_ST_RD_STAT = 7'b0010000,
		SEC_ST_HOLD = 7'b0100000,
		SEC_ST_DROP = 7'b1000000
	} sec_state_e;
	// Command left behind by a session for the commit step
	typedef enum logic [2:0] {
		SEC_CMD_NONE = 3'h0,
		SEC_CMD_SET_WEL = 3'h1,
		SEC_CMD_CLR_WEL = 3'h2,
		SEC_CMD_WR_STAT = 3'h3,
		SEC_CMD_WRITE = 3'h4
	} sec_cmd_e;
	typedef struct packed {
		logic [1:0] protect;
		logic writeEnableLatch;
		logic busy;
	} sec_status_s;
endpackage

/* tb/sec_eeprom_asserts.sv */
// Port checker for the serial EEPROM command block
`timescale 1ns/10ps
`include "sec_cfg.svh"
module sec_eeprom_asserts (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic serialClk,
	input wire logic chipSelectN,
	input wire logic serialIn,
	input wire logic writeProtectN,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	logic [4:0] bitCount;
	logic [7:0] opcode;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Session bit count and first byte; deselect clears them, as in the device
	always_ff @(posedge serialClk or posedge chipSelectN) begin
		if (chipSelectN) begin
			bitCount <= 5'h00;
			opcode <= 8'h00;
		end else begin
			bitCount <= (bitCount == 5'h1f) ? bitCount : bitCount + 5'h01;
			opcode <= (bitCount < 5'h08) ? {opcode[6:0], serialIn} : opcode;
		end
	end
	a_oe_deselect: assert property (chipSelectN && $past(chipSelectN) |-> !serialOutEn)
		else $error("output enabled while deselected");
	a_out_idle: assert property (chipSelectN && $past(chipSelectN) |-> !serialOut)
		else $error("output not parked while deselected");
	a_out_on_fall: assert property (serialOutEn && $past(serialOutEn) && $changed(serialOut) |-> !serialClk)
		else $error("output moved off a falling edge");
	a_oe_rise_low: assert property ($rose(serialOutEn) |-> !serialClk && !chipSelectN)
		else $error("output enable rose at a wrong moment");
	a_oe_holds: assert property (serialOutEn && !chipSelectN ##1 !chipSelectN |-> serialOutEn)
		else $error("output enable dropped inside a session");
	a_oe_count: assert property ($rose(serialOutEn) |-> bitCount == 5'h08 || bitCount == 5'h10)
		else $error("answer after a wrong bit count");
	a_rd_opcode: assert property ($rose(serialOutEn) |-> (bitCount == 5'h08 && opcode == `SEC_OP_RD_STAT)
		|| (bitCount == 5'h10 && (opcode & `SEC_OP_HIADDR_MASK) == `SEC_OP_READ))
		else $error("answer to an opcode that reads nothing");
	a_status_ones: assert property ($rose(serialOutEn) && bitCount == 5'h08 |-> serialOut)
		else $error("status top bit not one");
endmodule
bind sec_eeprom sec_eeprom_asserts sec_eeprom_asserts_i (.ref_clk(ref_clk), .reset(reset), .serialClk(serialClk),
	.chipSelectN(chipSelectN), .serialIn(serialIn), .writeProtectN(writeProtectN), .serialOut(serialOut),
	.serialOutEn(serialOutEn));

/* tb/sec_host_model.sv */
// Host serial controller model for the EEPROM link
`timescale 1ns/10ps
module sec_host_model (
	output logic serialClk,
	output logic chipSelectN,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	logic cpol;
	// Idle: deselected, clock parked and still between frames
	initial begin
		cpol = 1'b0;
		serialClk = 1'b0;
		chipSelectN = 1'b1;
		serialIn = 1'b0;
	end
	// Odd offset keeps link edges off the reference clock edges for a session started on one
	task automatic csLow();
		#3 serialClk <= cpol;
		#16 chipSelectN <= 1'b0;
		#16;
	endtask
	// Data set while clock low, MSB first; reads x if the device is not driving
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			serialClk <= 1'b0;
			serialIn <= tx[i];
			#16;
			rx[i] = serialOutEn ? serialOut : 1'bx;
			serialClk <= 1'b1;
			#16;
		end
	endtask
	// Deselect right after the last bit; released data line shows the inverse
	task automatic csHigh();
		serialClk <= cpol;
		#8 chipSelectN <= 1'b1;
		serialIn <= ~serialIn;
		#64;
	endtask
endmodule

/* tb/sec_eeprom_tb.sv */
// Self-checking bench for the serial EEPROM command block
`timescale 1ns/10ps
module sec_eeprom_tb;
	import sec_pkg::*;
	logic ref_clk, reset, writeProtectN, serialClk, chipSelectN, serialIn, serialOut, serialOutEn;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	sec_byte_t mem [0:511];
	sec_byte_t r;
	sec_addr_t probe [4] = '{9'h0ff, 9'h100, 9'h17f, 9'h180};
	sec_eeprom #(.ProgCycles(300)) sec_eeprom_i (.ref_clk(ref_clk), .reset(reset), .serialClk(serialClk),
		.chipSelectN(chipSelectN), .serialIn(serialIn), .writeProtectN(writeProtectN), .serialOut(serialOut),
		.serialOutEn(serialOutEn));
	sec_host_model sec_host_model_i (.serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn));
	// Reference clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic final_report();
		if (fails == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Hang guard, well above the expected run length
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			final_report();
		end
	end
	task automatic check(input sec_byte_t seen, input sec_byte_t exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd2(input sec_byte_t op, input sec_byte_t b, output sec_byte_t d);
		sec_host_model_i.csLow();
		sec_host_model_i.xfer(op, d);
		sec_host_model_i.xfer(b, d);
		sec_host_model_i.csHigh();
	endtask
	task automatic cmd(input sec_byte_t op);
		sec_byte_t d;
		sec_host_model_i.csLow();
		sec_host_model_i.xfer(op, d);
		sec_host_model_i.csHigh();
	endtask
	task automatic stat(input sec_byte_t exp);
		sec_byte_t d;
		cmd2(`SEC_OP_RD_STAT, 8'h00, d);
		check(d, exp);
	endtask
	// Status polling, bounded so a stuck busy shows as a mismatch
	task automatic poll(output sec_byte_t s);
		s = 8'hff;
		for (int k = 0; k < 50 && s[0] !== 1'b0; k++) begin
			cmd2(`SEC_OP_RD_STAT, 8'h00, s);
		end
	endtask
	task automatic pin(input int n);
		@(posedge ref_clk) writeProtectN <= 1'b0;
		repeat (n) @(posedge ref_clk);
		writeProtectN <= 1'b1;
	endtask
	// Write n bytes; wpm 1 pin low, 2 pin pulse in session, 3 pin pulse while busy, 4 no latch
	task automatic wr(input sec_addr_t a, input int n, input sec_byte_t d, input bit ok, input int wpm);
		sec_byte_t x;
		if (wpm != 4) begin
			cmd(`SEC_OP_SET_WEL);
		end
		@(posedge ref_clk) writeProtectN <= (wpm != 1);
		sec_host_model_i.csLow();
		sec_host_model_i.xfer(`SEC_OP_WRITE | {4'h0, a[8], 3'h0}, x);
		sec_host_model_i.xfer(a[7:0], x);
		for (int i = 0; i < n; i++) begin
			sec_host_model_i.xfer(d + i[7:0], x);
			if (ok) begin
				mem[{a[8:5], a[4:0] + i[4:0]}] = d + i[7:0];
			end
		end
		if (wpm == 2) begin
			pin(4);
		end
		sec_host_model_i.csHigh();
		if (wpm == 3) begin
			pin(40);
		end
		@(posedge ref_clk) writeProtectN <= 1'b1;
		if (ok) begin
			cmd(`SEC_OP_CLR_WEL);
			cmd2(`SEC_OP_RD_STAT, 8'h00, x);
			check(x & 8'hf3, 8'hf3);
		end
		poll(x);
		check(x & 8'hf3, (ok || wpm == 4) ? 8'hf0 : 8'hf2);
	endtask
	task automatic rd(input sec_addr_t a, input int n);
		sec_byte_t x;
		sec_host_model_i.csLow();
		sec_host_model_i.xfer(`SEC_OP_READ | {4'h0, a[8], 3'h0}, x);
		sec_host_model_i.xfer(a[7:0], x);
		for (int i = 0; i < n; i++) begin
			sec_host_model_i.xfer(8'h00, x);
			check(x, mem[a + i[8:0]]);
		end
		sec_host_model_i.csHigh();
	endtask
	// Status write with stray bits set outside 3:2
	task automatic setProt(input logic [1:0] p);
		cmd(`SEC_OP_SET_WEL);
		cmd2(`SEC_OP_WR_STAT, {4'h0, p, 2'b11}, r);
		poll(r);
		check(r, {4'hf, p, 2'b00});
	endtask
	initial begin
		reset = 1'b1;
		writeProtectN = 1'b1;
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		stat(8'hf0);
		cmd(`SEC_OP_SET_WEL);
		stat(8'hf2);
		cmd(`SEC_OP_CLR_WEL);
		stat(8'hf0);
		cmd2(`SEC_OP_SET_WEL, 8'h00, r);
		stat(8'hf0);
		cmd2(8'h07, 8'h00, r);
		check(r, 8'hxx);
		cmd(8'h16);
		stat(8'hf0);
		for (int p = 3; p >= 0; p--) begin
			setProt(p[1:0]);
			for (int j = 0; j < 4; j++) begin
				wr(probe[j], 1, {p[1:0], j[1:0], 4'h9}, !(p == 3 || (p == 2 && probe[j] >= 9'h100)
					|| (p == 1 && probe[j] >= 9'h180)), 0);
				rd(probe[j], 1);
			end
		end
		wr(9'h000, 1, 8'h5a, 1, 0);
		wr(9'h000, 1, 8'h11, 0, 4);
		wr(9'h1fe, 4, 8'ha0, 1, 0);
		wr(9'h050, 1, 8'h22, 0, 1);
		wr(9'h051, 1, 8'h33, 0, 2);
		wr(9'h052, 1, 8'h44, 1, 3);
		sec_host_model_i.cpol = 1'b1;
		rd(9'h1fe, 3);
		rd(9'h1e0, 2);
		rd(9'h050, 3);
		final_report();
	end
endmodule
